// File: pkg/adcsq_pkg.sv
package adcsq_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0] OFS_MODE      = 8'h00; // converter_mode_reg_zero
    localparam logic [7:0] OFS_CHSEL     = 8'h04; // channel_select_reg
    localparam logic [7:0] OFS_PFMODE    = 8'h08; // powerfail_mode_reg
    localparam logic [7:0] OFS_PFTHR     = 8'h0C; // powerfail_threshold_reg
    localparam logic [7:0] OFS_STATUS    = 8'h10; // sticky interrupt status
    localparam logic [7:0] OFS_MASK      = 8'h14; // interrupt mask
    localparam logic [7:0] OFS_RESULT0   = 8'h40; // channel_result_reg 0..11
    localparam int         NUM_CH        = 12;    // result registers 0 to 11
    localparam int         RES_W         = 10;    // conversion width
    // mode register field positions
    localparam int         POS_CE        = 7;     // conversion_enable_bit
    localparam int         POS_BUSY      = 6;     // conversion in progress (read only)
    localparam int         POS_MD        = 4;     // op_mode_field low bit
    // powerfail mode register field positions
    localparam int         POS_PFE       = 7;     // powerfail_compare_enable
    localparam int         POS_PFC       = 6;     // powerfail_condition_select
    // reset values
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    // op modes
    localparam logic [1:0] MD_CONT_SEL   = 2'h0;
    localparam logic [1:0] MD_CONT_SCAN  = 2'h1;
    localparam logic [1:0] MD_ONE_SEL    = 2'h2;
    localparam logic [1:0] MD_ONE_SCAN   = 2'h3;

    // request to the converter core and its answer
    typedef struct packed {
        logic       start;    // one-cycle start pulse
        logic [3:0] channel;  // analog input to sample
    } adcsq_req_type;
    typedef struct packed {
        logic             done;   // one-cycle completion pulse
        logic [RES_W-1:0] data;   // conversion result
    } adcsq_rsp_type;
endpackage

// File: logic/adcsq_sequencer.sv
// Notes on behaviour
// - continuous scan: channel 0 up to selected
// - scan stores each result per channel
// - scan end: interrupt, restart unless disabled
// - twelve result registers, one per channel
// - one-shot select: convert once, interrupt, stop
// - one-shot scan: 0 to selected, halt
// - compare off: interrupt every completed pass (scan: last channel only)
// - condition zero: interrupt if high byte >= threshold
// - condition one: interrupt if high byte < threshold
// - select compare: always store, gate interrupt
// - compare continuous select repeats while enabled
// - compare scan: only channel zero decides
// - compare continuous scan restarts while enabled
// - compare one-shot select stops after one
// - compare one-shot scan stops after sequence
// - enable cleared: stop converting
// - enable set starts selected conversions
// - two-bit mode field picks mode
`timescale 1ns/1ps
module adcsq_sequencer
    import adcsq_pkg::*;
(
    input  wire logic          ref_clk,  // 10 mhz clock
    input  wire logic          srst,     // synchronous reset, active high
    input  wire logic          psel,     // apb select
    input  wire logic          penable,  // apb access phase
    input  wire logic          pwrite,   // apb direction
    input  wire logic [7:0]    paddr,    // apb byte address
    input  wire logic [31:0]   pwdata,   // apb write data
    output logic      [31:0]   prdata,   // apb read data
    output logic               pready,   // apb ready
    output logic               pslverr,  // apb error
    output adcsq_req_type      convReq,  // start request to the core
    input  wire adcsq_rsp_type convRsp,  // completion from the core
    output logic               irq       // level interrupt
);
    // states of the sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,  // not converting
        ST_KICK = 3'b010,  // issue start pulse
        ST_WAIT = 3'b100   // wait for the core
    } adcsq_state_type;

    adcsq_state_type   state_r;                  // sequencer state
    logic              ceBit_r;                  // conversion enable
    logic [1:0]        opMode_r;                 // mode field
    logic [3:0]        chSel_r;                  // channel select
    logic              pfEnable_r;               // compare enable
    logic              pfCond_r;                 // compare condition
    logic [7:0]        pfThr_r;                  // compare threshold
    logic              status_r;                 // sticky conversion end flag
    logic              mask_r;                   // interrupt mask, 1 enables
    logic [3:0]        curCh_r;                  // channel under conversion
    logic [RES_W-1:0]  result_r [NUM_CH];        // per-channel results
    logic [7:0]        cr0High_r;                // channel zero high byte this pass
    logic              wrEn;                     // apb write strobe
    logic              rdEn;                     // apb access strobe
    logic              cfgWr;                    // write to a configuration register
    logic              isScan;                   // scan type mode
    logic              lastCh;                   // current channel ends the pass
    logic              passDone;                 // completion that ends the pass
    logic              cmpOk;                    // compare passes
    logic              convEnd;                  // conversion-end event
    logic [7:0]        cmpByte;                  // byte entering compare

    // zero-wait apb: every access completes in its access cycle
    assign pready  = 1'b1;
    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && penable;
    assign cfgWr   = wrEn && (paddr == OFS_MODE || paddr == OFS_CHSEL ||
                              paddr == OFS_PFMODE || paddr == OFS_PFTHR);

    // unmapped or misaligned address answers with an error
    function automatic logic addrMapped(input logic [7:0] a);
        logic hit;
        hit = (a[1:0] == 2'b00) && ((a <= OFS_MASK) ||
              (a >= OFS_RESULT0 && a < OFS_RESULT0 + 8'(4 * NUM_CH)));
        return hit;
    endfunction
    assign pslverr = rdEn && !addrMapped(paddr);

    // configuration registers written by software
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ceBit_r    <= 1'b0;
            opMode_r   <= MD_CONT_SEL;
            chSel_r    <= 4'h0;
            pfEnable_r <= 1'b0;
            pfCond_r   <= 1'b0;
            pfThr_r    <= 8'h00;
            mask_r     <= 1'b0;
        end else begin
            if (wrEn && paddr == OFS_MODE) begin
                ceBit_r  <= pwdata[POS_CE];
                opMode_r <= pwdata[POS_MD +: 2];
            end else if (state_r == ST_WAIT && convRsp.done && passDone &&
                         (opMode_r == MD_ONE_SEL || opMode_r == MD_ONE_SCAN)) begin
                ceBit_r <= 1'b0; // one-shot drops enable when done
            end
            // channels above eleven are clamped to eleven so the select always names an existing result register
            if (wrEn && paddr == OFS_CHSEL) begin
                chSel_r <= (pwdata[3:0] > 4'(NUM_CH - 1)) ? 4'(NUM_CH - 1) : pwdata[3:0];
            end
            if (wrEn && paddr == OFS_PFMODE) begin
                pfEnable_r <= pwdata[POS_PFE];
                pfCond_r   <= pwdata[POS_PFC];
            end
            if (wrEn && paddr == OFS_PFTHR) begin
                pfThr_r <= pwdata[7:0];
            end
            if (wrEn && paddr == OFS_MASK) begin
                mask_r <= pwdata[0];
            end
        end
    end

    // pass bookkeeping
    assign isScan   = (opMode_r == MD_CONT_SCAN) || (opMode_r == MD_ONE_SCAN);
    assign lastCh   = !isScan || (curCh_r == chSel_r);
    assign passDone = lastCh;

    // compare byte: in scan modes only channel zero decides
    always_comb begin
        if (isScan && curCh_r != 4'h0) begin
            cmpByte = cr0High_r;
        end else begin
            cmpByte = convRsp.data[RES_W-1 -: 8];
        end
    end

    // power-fail compare
    always_comb begin
        if (!pfEnable_r) begin
            cmpOk = 1'b1;
        end else if (!pfCond_r) begin
            cmpOk = (cmpByte >= pfThr_r);
        end else begin
            cmpOk = (cmpByte < pfThr_r);
        end
    end

    // event: completion at pass end with compare passing
    assign convEnd = (state_r == ST_WAIT) && convRsp.done && passDone && cmpOk;

    // sequencer state machine; config writes abort and restart
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            curCh_r <= 4'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (ceBit_r) begin
                        state_r <= ST_KICK;
                        curCh_r <= isScan ? 4'h0 : chSel_r;
                    end
                end
                ST_KICK: begin
                    if (!ceBit_r) begin
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!ceBit_r || cfgWr) begin
                        state_r <= ST_IDLE;
                    end else if (convRsp.done) begin
                        if (!passDone) begin
                            curCh_r <= curCh_r + 4'h1;
                            state_r <= ST_KICK;
                        end else if (opMode_r == MD_ONE_SEL || opMode_r == MD_ONE_SCAN) begin
                            state_r <= ST_IDLE;
                        end else begin
                            // restart at channel zero or same channel
                            curCh_r <= isScan ? 4'h0 : chSel_r;
                            state_r <= ST_KICK;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // start pulse to the core
    assign convReq.start   = (state_r == ST_KICK) && ceBit_r;
    assign convReq.channel = curCh_r;

    // result storage, one register per channel; always stored
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : gRes
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    result_r[g] <= '0;
                end else if (state_r == ST_WAIT && convRsp.done && curCh_r == 4'(g)) begin
                    result_r[g] <= convRsp.data;
                end
            end
        end
    endgenerate

    // channel zero high byte held for the rest of a scan pass
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cr0High_r <= 8'h00;
        end else if (state_r == ST_WAIT && convRsp.done && curCh_r == 4'h0) begin
            cr0High_r <= convRsp.data[RES_W-1 -: 8];
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_r <= 1'b0;
        end else if (convEnd) begin
            status_r <= 1'b1;
        end else if (wrEn && paddr == OFS_STATUS && pwdata[0]) begin
            status_r <= 1'b0;
        end
    end

    assign irq = status_r && mask_r;

    // read mux
    always_comb begin
        prdata = RST_ZERO;
        if (rdEn && !pwrite) begin
            case (paddr)
                OFS_MODE: begin
                    prdata[POS_CE]      = ceBit_r;
                    prdata[POS_BUSY]    = (state_r != ST_IDLE);
                    prdata[POS_MD +: 2] = opMode_r;
                end
                OFS_CHSEL:  prdata[3:0] = chSel_r;
                OFS_PFMODE: begin
                    prdata[POS_PFE] = pfEnable_r;
                    prdata[POS_PFC] = pfCond_r;
                end
                OFS_PFTHR:  prdata[7:0] = pfThr_r;
                OFS_STATUS: prdata[0]   = status_r;
                OFS_MASK:   prdata[0]   = mask_r;
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (paddr == OFS_RESULT0 + 8'(4 * i)) begin
                            prdata[RES_W-1:0] = result_r[i];
                        end
                    end
                end
            endcase
        end
    end

    // checks
    a_oneshot_halts: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && ceBit_r && !cfgWr &&
         opMode_r == MD_ONE_SEL) |=> state_r == ST_IDLE && !ceBit_r)
        else $error("one-shot did not halt");
    a_scan_restart: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && ceBit_r && !cfgWr &&
         opMode_r == MD_CONT_SCAN) |=> curCh_r == 4'h0 && state_r == ST_KICK)
        else $error("scan did not restart at zero");
    a_scan_advance: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && !passDone && ceBit_r && !cfgWr)
        |=> curCh_r == $past(curCh_r) + 4'h1)
        else $error("scan did not advance");
    a_store_result: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done) |=> result_r[$past(curCh_r)] == $past(convRsp.data))
        else $error("result not stored");
    a_nocmp_irq: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && !pfEnable_r) |=> status_r)
        else $error("event missed without compare");
    a_ge_gate: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && !isScan && pfEnable_r &&
         !pfCond_r && convRsp.data[9:2] < pfThr_r && !status_r) |=> !status_r)
        else $error("event raised below threshold");
    a_lt_gate: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && !isScan && pfEnable_r &&
         pfCond_r && convRsp.data[9:2] < pfThr_r) |=> status_r)
        else $error("event missed below threshold");
    a_disable_stop: assert property (@(posedge ref_clk) disable iff (srst)
        !ceBit_r |=> !convReq.start)
        else $error("start while disabled");
    a_irq_level: assert property (@(posedge ref_clk) disable iff (srst)
        irq == (status_r && mask_r))
        else $error("irq mismatch");

    // continuous select keeps converting the same channel while enabled
    a_sel_repeat: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && ceBit_r && !cfgWr &&
         opMode_r == MD_CONT_SEL) |=> state_r == ST_KICK && curCh_r == $past(chSel_r))
        else $error("continuous select did not repeat");

    // one-shot scan halts after the last selected channel
    a_scan_halts: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && passDone && ceBit_r && !cfgWr &&
         opMode_r == MD_ONE_SCAN) |=> state_r == ST_IDLE && !ceBit_r)
        else $error("one-shot scan did not halt");

    // channel zero high byte is the top eight bits of its result
    a_zero_byte: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && convRsp.done && curCh_r == 4'h0)
        |=> cr0High_r == $past(convRsp.data[RES_W-1 -: 8]))
        else $error("channel zero byte not captured");

    // select value never names a result register that does not exist
    a_sel_clamp: assert property (@(posedge ref_clk) disable iff (srst)
        chSel_r <= 4'(NUM_CH - 1))
        else $error("channel select out of range");

    // a clear without a coinciding event empties the flag
    a_status_clr: assert property (@(posedge ref_clk) disable iff (srst)
        (wrEn && paddr == OFS_STATUS && pwdata[0] && !convEnd) |=> !status_r)
        else $error("status not cleared");

    // a configuration write during a conversion aborts it
    a_cfg_abort: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && cfgWr) |=> state_r == ST_IDLE)
        else $error("conversion not aborted");

    c_oneshot_scan: cover property (@(posedge ref_clk) disable iff (srst)
        opMode_r == MD_ONE_SCAN && convEnd);
    c_cont_sel: cover property (@(posedge ref_clk) disable iff (srst)
        opMode_r == MD_CONT_SEL && convEnd && pfEnable_r);
    c_scan_pass: cover property (@(posedge ref_clk) disable iff (srst)
        opMode_r == MD_CONT_SCAN && convEnd);
    c_oneshot_sel: cover property (@(posedge ref_clk) disable iff (srst)
        opMode_r == MD_ONE_SEL && convEnd);
    c_pf_block: cover property (@(posedge ref_clk) disable iff (srst)
        state_r == ST_WAIT && convRsp.done && passDone && !cmpOk);
endmodule

// File: verification/adcsq_core_model.sv
`timescale 1ns/1ps
module adcsq_core_model
    import adcsq_pkg::*;
(
    input  wire logic          ref_clk,        // system clock
    input  wire adcsq_req_type convReq,        // start request from the sequencer
    input  wire logic [9:0]    chVal [NUM_CH], // analog value seen on each input
    input  wire logic [3:0]    lat,            // cycles from start to done, at least one
    output adcsq_rsp_type      convRsp         // completion towards the sequencer
);
    logic       busy_r = 1'b0; // a conversion is running
    logic [3:0] cnt_r  = 4'h0; // cycles left in the running conversion
    logic [3:0] ch_r   = 4'h0; // channel being sampled
    initial convRsp = '0;
    // one conversion at a time; the data lines toggle outside done so a
    // sequencer that samples them at the wrong moment stores garbage
    always @(posedge ref_clk) begin
        convRsp.done <= 1'b0;
        convRsp.data <= ~convRsp.data;
        if (convReq.start === 1'b1) begin
            busy_r <= 1'b1;
            cnt_r  <= lat;
            ch_r   <= convReq.channel;
        end else if (busy_r && cnt_r == 4'h1) begin
            busy_r       <= 1'b0;
            convRsp.done <= 1'b1;
            convRsp.data <= chVal[ch_r];
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb
    import adcsq_pkg::*;
;
    logic          ref_clk = 1'b0;          // 10 mhz bench clock
    logic          srst    = 1'b1;          // synchronous reset
    logic          psel    = 1'b0;          // apb select
    logic          penable = 1'b0;          // apb access phase
    logic          pwrite  = 1'b0;          // apb direction
    logic [7:0]    paddr   = 8'h00;         // apb address
    logic [31:0]   pwdata  = 32'h0000_0000; // apb write data
    logic [31:0]   prdata;                  // apb read data
    logic          pready;                  // apb ready
    logic          pslverr;                 // apb error
    logic          irq;                     // level interrupt
    adcsq_req_type convReq;                 // start towards the core
    adcsq_rsp_type convRsp;                 // answer from the core
    logic [9:0]    chVal [NUM_CH];          // analog value per channel
    logic [3:0]    lat     = 4'h1;          // core latency in cycles
    logic [32:0]   expQ[$];                 // expected {pslverr, prdata}
    logic [32:0]   mskQ[$];                 // bits of each answer that matter
    logic [3:0]    chLog[$];                // channel of every start seen
    int            doneCnt = 0;             // completions seen
    int            n_fail  = 0;             // mismatches
    int            comparisons = 0;         // comparisons made
    logic [7:0]    hb;                      // high byte under test
    logic [7:0]    thr;                     // threshold under test
    int            nst;                     // start count snapshot

    always #50 ref_clk = ~ref_clk;

    adcsq_sequencer dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convReq(convReq), .convRsp(convRsp), .irq(irq));
    adcsq_core_model core (.ref_clk(ref_clk), .convReq(convReq), .chVal(chVal), .lat(lat),
        .convRsp(convRsp));

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // one apb transfer; the answer is noted for the watcher below
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        int k;
        expQ.push_back(e);
        mskQ.push_back(m);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge: no double drive of psel, and a landed write is visible
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0_0000_0000, 33'h1_0000_0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000, {1'b0, e}, 33'h1_FFFF_FFFF);
    endtask
    task automatic wait_done(input int n);
        int t;
        t = doneCnt + n;
        for (int k = 0; k < 2000 && doneCnt < t; k++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
    endtask
    function automatic logic [31:0] mreg(input logic [1:0] md, input logic ce);
        return (32'(ce) << POS_CE) | (32'(md) << POS_MD);
    endfunction
    function automatic logic [7:0] res(input int ch);
        return OFS_RESULT0 + 8'(4 * ch);
    endfunction

    // watcher: compare every apb answer in the access cycle, where it is settled
    always @(negedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && expQ.size() > 0)
            check($sformatf("apb %h", paddr), {pslverr, prdata} & mskQ.pop_front(),
                  expQ.pop_front());
    end
    // log starts and completions of the core
    always @(posedge ref_clk) begin
        if (convReq.start === 1'b1) chLog.push_back(convReq.channel);
        if (convRsp.done === 1'b1) doneCnt++;
    end
    // hang guard: the whole sequence needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hc8ba74af));
        foreach (chVal[i]) chVal[i] = 10'($urandom % 1000);
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_MODE, RST_ZERO);
        rd(OFS_STATUS, RST_ZERO);
        rd(res(11), RST_ZERO);
        apb(8'h3C, 1'b0, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000);
        wr(OFS_MASK, 32'h0000_0001);
        $display("test reset done");
        // one-shot select, prompt and slow core
        for (int s = 0; s < 2; s++) begin
            lat = s ? 4'h9 : 4'h1;
            chLog.delete();
            wr(OFS_CHSEL, 32'h0000_0005);
            wr(OFS_MODE, mreg(MD_ONE_SEL, 1'b1));
            wait_done(1);
            repeat (20) @(posedge ref_clk);
            check("one-shot starts", 33'(chLog.size()), 33'h0_0000_0001);
            check("irq", 33'(irq), 33'h0_0000_0001);
            rd(res(5), 32'(chVal[5]));
            rd(OFS_MODE, mreg(MD_ONE_SEL, 1'b0));
            wr(OFS_STATUS, 32'h0000_0001);
            check("irq cleared", 33'(irq), 33'h0_0000_0000);
        end
        $display("test one-shot select done");
        // one-shot scan to channel 3
        chLog.delete();
        lat = 4'h4;
        wr(OFS_CHSEL, 32'h0000_0003);
        wr(OFS_MODE, mreg(MD_ONE_SCAN, 1'b1));
        wait_done(4);
        repeat (20) @(posedge ref_clk);
        check("scan starts", 33'(chLog.size()), 33'h0_0000_0004);
        for (int i = 0; i < 4; i++) begin
            check("scan order", 33'(chLog[i]), 33'(i));
            rd(res(i), 32'(chVal[i]));
        end
        rd(OFS_STATUS, 32'h0000_0001);
        wr(OFS_STATUS, 32'h0000_0001);
        $display("test one-shot scan done");
        // compare on, one-shot select, both conditions at the boundary
        for (int c = 0; c < 2; c++) for (int d = 0; d < 2; d++) begin
            chVal[5] = 10'($urandom % 1000);
            hb = chVal[5][9:2];
            thr = hb + 8'(d);
            wr(OFS_PFMODE, (32'h0000_0001 << POS_PFE) | (32'(c) << POS_PFC));
            wr(OFS_PFTHR, 32'(thr));
            wr(OFS_CHSEL, 32'h0000_0005);
            wr(OFS_MODE, mreg(MD_ONE_SEL, 1'b1));
            wait_done(1);
            rd(OFS_STATUS, 32'(c == d));
            rd(res(5), 32'(chVal[5]));
            wr(OFS_STATUS, 32'h0000_0001);
        end
        $display("test compare select done");
        // compare on, one-shot scan: only channel 0 decides
        for (int c = 0; c < 2; c++) begin
            chVal[2] = 10'h3FF;
            wr(OFS_PFMODE, (32'h0000_0001 << POS_PFE) | (32'(c) << POS_PFC));
            wr(OFS_PFTHR, 32'(chVal[0][9:2] + 8'h01));
            wr(OFS_CHSEL, 32'h0000_0002);
            wr(OFS_MODE, mreg(MD_ONE_SCAN, 1'b1));
            wait_done(3);
            rd(OFS_STATUS, 32'(c));
            rd(res(2), 32'h0000_03FF);
            wr(OFS_STATUS, 32'h0000_0001);
        end
        $display("test compare scan done");
        // continuous scan with compare off, random core latency
        chLog.delete();
        lat = 4'($urandom_range(8, 1));
        wr(OFS_PFMODE, RST_ZERO);
        wr(OFS_MODE, mreg(MD_CONT_SCAN, 1'b1));
        wait_done(6);
        rd(OFS_STATUS, 32'h0000_0001);
        wr(OFS_MODE, mreg(MD_CONT_SCAN, 1'b0));
        nst = chLog.size();
        repeat (40) @(posedge ref_clk);
        check("stop starts", 33'(chLog.size()), 33'(nst));
        for (int i = 0; i < 6; i++) check("rescan", 33'(chLog[i]), 33'(i % 3));
        for (int i = 0; i < 3; i++) rd(res(i), 32'(chVal[i]));
        wr(OFS_STATUS, 32'h0000_0001);
        $display("test continuous scan done");
        // compare on, continuous select and continuous scan keep going
        for (int s = 0; s < 2; s++) begin
            chLog.delete();
            wr(OFS_PFMODE, 32'h0000_0001 << POS_PFE);
            wr(OFS_PFTHR, RST_ZERO);
            wr(OFS_CHSEL, 32'h0000_0007);
            wr(OFS_MODE, mreg(s ? MD_CONT_SCAN : MD_CONT_SEL, 1'b1));
            wait_done(s ? 16 : 3);
            wr(OFS_MODE, RST_ZERO);
            check("restart", 33'(chLog[s ? 8 : 2]), 33'h0_0000_0000 + 33'(s ? 0 : 7));
            rd(res(7), 32'(chVal[7]));
            wr(OFS_MASK, RST_ZERO);
            check("masked", 33'(irq), 33'h0_0000_0000);
            wr(OFS_MASK, 32'h0000_0001);
            check("unmasked", 33'(irq), 33'h0_0000_0001);
            wr(OFS_STATUS, 32'h0000_0001);
        end
        $display("test continuous compare done");
        tally_and_finish();
    end
endmodule
